/* rtl/tfc_defines.svh */
// Purpose: Offsets, fields, reset values and timing counts of the transmit framer
// Assumes: 100 MHz sys_clk, 13.56 MHz carrier reference for wait units
// Notes: Included by bare name; definitions only
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH

`define TFC_ADDR_BURST 8'h30
`define TFC_ADDR_WCTRL 8'h31
`define TFC_ADDR_WLO 8'h32
`define TFC_ADDR_FRAME 8'h33

`define TFC_WCTRL_RST 8'hC0
`define TFC_WLO_RST 8'h00
`define TFC_FRAME_RST 8'h00
`define TFC_BURST_RST 8'h00

`define TFC_ORIGIN_BIT 7
`define TFC_UNIT_BIT 6
`define TFC_WHIGH_MSB 5
`define TFC_WHIGH_LSB 3
`define TFC_STOP_MSB 2
`define TFC_STOP_LSB 0
`define TFC_TXPAR_BIT 7
`define TFC_RXPAR_BIT 6
`define TFC_CLOSE_MSB 3
`define TFC_CLOSE_LSB 2
`define TFC_OPEN_MSB 1
`define TFC_OPEN_LSB 0
`define TFC_BURST_MSB 6
`define TFC_BURST_LSB 4

`define TFC_CLK_KHZ 100000
`define TFC_CARRIER_KHZ 13560
`define TFC_WAIT_CARRIER_PERIODS 16
`define TFC_CARRIER_UNIT_CYC \
  ((`TFC_WAIT_CARRIER_PERIODS * `TFC_CLK_KHZ + `TFC_CARRIER_KHZ - 1) / `TFC_CARRIER_KHZ)
`define TFC_HALF_BIT_NS 18880
`define TFC_HALF_BIT_CYC ((`TFC_HALF_BIT_NS * `TFC_CLK_KHZ) / 1000000)
`define TFC_ODD_PARITY 1'b1
`define TFC_FIFO_DEPTH 16

`endif

/* rtl/tfc_pkg.sv */
// Purpose: Types shared by the transmit framer files
// Assumes: Nothing beyond the defines header
// Notes: Burst length table lives here as one function
package tfc_pkg;
  typedef logic [7:0] tfc_byte_t;
  typedef enum logic [2:0] {
    TFC_IDLE, TFC_OPEN, TFC_DATA, TFC_PAR, TFC_STOP, TFC_EGT, TFC_CLOSE
  } tfc_state_e;

  function automatic logic [8:0] tfc_burst_bits(input logic [2:0] code);
    case (code)
      3'h0: tfc_burst_bits = 9'h008;
      3'h1: tfc_burst_bits = 9'h010;
      3'h2: tfc_burst_bits = 9'h020;
      3'h3: tfc_burst_bits = 9'h030;
      3'h4: tfc_burst_bits = 9'h040;
      3'h5: tfc_burst_bits = 9'h060;
      3'h6: tfc_burst_bits = 9'h080;
      default: tfc_burst_bits = 9'h100;
    endcase
  endfunction : tfc_burst_bits
endpackage : tfc_pkg

/* rtl/tfc_fifo.sv */
// Purpose: Flip-flop FIFO between the byte source and the serialiser
// Assumes: Same clock on both sides
// Notes: inReady is registered so it can leave the top directly
module tfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("tfc_fifo needs DEPTH of 2 or more");
  end

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD;
  logic [CW-1:0] countQ, countD;
  logic readyQ, readyD;
  logic doWr, doRd;

  assign doWr = inValid && readyQ;
  assign doRd = outReady && (countQ != '0);
  assign inReady = readyQ;
  assign outValid = (countQ != '0);
  assign outData = memQ[rdPtrQ];

  always_comb begin
    wrPtrD = wrPtrQ;
    rdPtrD = rdPtrQ;
    countD = countQ;
    if (doWr) begin
      wrPtrD = (wrPtrQ == AW'(DEPTH - 1)) ? '0 : wrPtrQ + 1'b1;
    end
    if (doRd) begin
      rdPtrD = (rdPtrQ == AW'(DEPTH - 1)) ? '0 : rdPtrQ + 1'b1;
    end
    if (doWr && !doRd) begin
      countD = countQ + 1'b1;
    end else if (doRd && !doWr) begin
      countD = countQ - 1'b1;
    end
    readyD = (countD != CW'(DEPTH));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
      readyQ <= 1'b1;
    end else begin
      wrPtrQ <= wrPtrD;
      rdPtrQ <= rdPtrD;
      countQ <= countD;
      readyQ <= readyD;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      memQ[wrPtrQ] <= inData;
    end
  end
endmodule : tfc_fifo

/* rtl/tfc_framer.sv */
// Purpose: Transmit framing with guard wait, symbols, parity, stop and guard bits
// Assumes: Receiver bits and frame end come from logic on sys_clk
// Notes: Bits go out LSB first, one per bit period, on the bit grid
`include "tfc_defines.svh"
module tfc_framer #(
  parameter int HALF_BIT_CYC = `TFC_HALF_BIT_CYC,
  parameter int FIFO_DEPTH = `TFC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWe,
  input wire logic regRe,
  input wire tfc_pkg::tfc_byte_t regWdata,
  output tfc_pkg::tfc_byte_t regRdata,
  input wire tfc_pkg::tfc_byte_t txByte,
  input wire logic txByteValid,
  output logic txByteReady,
  input wire logic txStart,
  input wire logic typeBMode,
  output logic txOut,
  output logic [1:0] txSymbol,
  output logic txActive,
  output logic waitBusy,
  input wire logic rxBit,
  input wire logic rxBitValid,
  input wire logic rxFrameEnd,
  output tfc_pkg::tfc_byte_t rxByte,
  output logic rxByteValid,
  output logic rxParityErr
);
  import tfc_pkg::*;

  localparam int CARR_CYC = `TFC_CARRIER_UNIT_CYC;
  if (HALF_BIT_CYC < 1 || HALF_BIT_CYC > 4095 || FIFO_DEPTH < 2) begin : g_chk
    $error("tfc_framer parameters out of range");
  end

  // Registers
  tfc_byte_t wctrlQ, wctrlD, wloQ, wloD, frameQ, frameD, burstQ, burstD, rdQ, rdD;
  always_comb begin
    wctrlD = wctrlQ;
    wloD = wloQ;
    frameD = frameQ;
    burstD = burstQ;
    rdD = 8'h00;
    if (regWe) begin
      if (regAddr == `TFC_ADDR_BURST) begin
        burstD = regWdata & 8'h70;
      end else if (regAddr == `TFC_ADDR_WCTRL) begin
        wctrlD = regWdata;
      end else if (regAddr == `TFC_ADDR_WLO) begin
        wloD = regWdata;
      end else if (regAddr == `TFC_ADDR_FRAME) begin
        frameD = regWdata & 8'hCF;
      end
    end
    if (regRe) begin
      if (regAddr == `TFC_ADDR_BURST) begin
        rdD = burstQ;
      end else if (regAddr == `TFC_ADDR_WCTRL) begin
        rdD = wctrlQ;
      end else if (regAddr == `TFC_ADDR_WLO) begin
        rdD = wloQ;
      end else if (regAddr == `TFC_ADDR_FRAME) begin
        rdD = frameQ;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wctrlQ <= `TFC_WCTRL_RST;
      wloQ <= `TFC_WLO_RST;
      frameQ <= `TFC_FRAME_RST;
      burstQ <= `TFC_BURST_RST;
      rdQ <= 8'h00;
    end else begin
      wctrlQ <= wctrlD;
      wloQ <= wloD;
      frameQ <= frameD;
      burstQ <= burstD;
      rdQ <= rdD;
    end
  end
  assign regRdata = rdQ;

  logic origin, unitEtu, txPar, rxPar;
  logic [10:0] waitCount;
  logic [2:0] stopLen;
  logic [1:0] closeSym, openSym;
  logic [8:0] burstBits;
  assign origin = wctrlQ[`TFC_ORIGIN_BIT];
  assign unitEtu = wctrlQ[`TFC_UNIT_BIT];
  assign waitCount = {wctrlQ[`TFC_WHIGH_MSB:`TFC_WHIGH_LSB], wloQ};
  assign stopLen = wctrlQ[`TFC_STOP_MSB:`TFC_STOP_LSB];
  assign txPar = frameQ[`TFC_TXPAR_BIT];
  assign rxPar = frameQ[`TFC_RXPAR_BIT];
  assign closeSym = frameQ[`TFC_CLOSE_MSB:`TFC_CLOSE_LSB];
  assign openSym = frameQ[`TFC_OPEN_MSB:`TFC_OPEN_LSB];
  assign burstBits = tfc_burst_bits(burstQ[`TFC_BURST_MSB:`TFC_BURST_LSB]);

  // Byte buffer
  tfc_byte_t fifoData;
  logic fifoValid, popD;
  tfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inData(txByte),
    .inValid(txByteValid),
    .inReady(txByteReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(popD)
  );

  // Bit rate divider, free running so frames keep the bit grid
  logic [11:0] halfDivQ, halfDivD;
  logic halfPhaseQ, halfPhaseD, halfTick, bitTick;
  assign halfTick = (halfDivQ == 12'h000);
  assign bitTick = halfTick && halfPhaseQ;
  always_comb begin
    halfDivD = halfTick ? 12'(HALF_BIT_CYC - 1) : halfDivQ - 12'h001;
    halfPhaseD = halfTick ? !halfPhaseQ : halfPhaseQ;
  end

  // Transmit sequencer
  tfc_state_e stateQ, stateD, nData, postData, postStop;
  logic [8:0] bitIdxQ, bitIdxD;
  tfc_byte_t curByteQ, curByteD;
  logic txOutQ, txOutD, activeQ, activeD, pendQ, pendD;
  logic [1:0] symQ, symD;
  logic [10:0] waitCntQ, waitCntD;
  logic [11:0] unitDivQ, unitDivD, unitLen;
  logic txEndEvt, loadWait, busyQ, busyD;

  always_comb begin
    postStop = (closeSym != 2'h0) ? TFC_CLOSE : TFC_IDLE;
    // stop and guard only for Type B
    postData = (typeBMode && stopLen != 3'h0) ? TFC_STOP : postStop;
    nData = fifoValid ? TFC_DATA : postData;
  end

  always_comb begin
    stateD = stateQ;
    bitIdxD = bitIdxQ;
    curByteD = curByteQ;
    txOutD = txOutQ;
    symD = symQ;
    activeD = activeQ;
    popD = 1'b0;
    pendD = pendQ || txStart;
    if (bitTick) begin
      case (stateQ)
        TFC_IDLE: begin
          if (pendQ && waitCntQ == 11'h000) begin
            pendD = txStart;
            bitIdxD = 9'h000;
            stateD = (openSym != 2'h0) ? TFC_OPEN : nData;
          end
        end
        TFC_OPEN: begin
          if (openSym == 2'h2 && bitIdxQ + 9'h001 < burstBits) begin
            bitIdxD = bitIdxQ + 9'h001;
          end else begin
            bitIdxD = 9'h000;
            stateD = nData;
          end
        end
        TFC_DATA: begin
          if (bitIdxQ == 9'h007) begin
            stateD = txPar ? TFC_PAR : nData;
          end else begin
            bitIdxD = bitIdxQ + 9'h001;
          end
        end
        TFC_PAR: stateD = nData;
        TFC_STOP: begin
          bitIdxD = 9'h000;
          stateD = (stopLen > 3'h1) ? TFC_EGT : postStop;
        end
        TFC_EGT: begin
          if (bitIdxQ + 9'h002 < {6'h00, stopLen}) begin
            bitIdxD = bitIdxQ + 9'h001;
          end else begin
            stateD = postStop;
          end
        end
        default: stateD = TFC_IDLE;
      endcase
      symD = 2'h0;
      activeD = (stateD != TFC_IDLE);
      case (stateD)
        TFC_IDLE: txOutD = 1'b0;
        TFC_OPEN: begin
          symD = openSym;
          txOutD = (openSym == 2'h2);
        end
        TFC_DATA: begin
          if (stateQ != TFC_DATA || bitIdxQ == 9'h007) begin
            curByteD = fifoData;
            popD = 1'b1;
            bitIdxD = 9'h000;
            txOutD = fifoData[0];
          end else begin
            txOutD = curByteQ[bitIdxD[2:0]];
          end
        end
        TFC_PAR: txOutD = (^curByteQ) ^ `TFC_ODD_PARITY;
        TFC_STOP, TFC_EGT: txOutD = 1'b1;
        default: begin
          symD = closeSym;
          txOutD = (closeSym == 2'h2);
        end
      endcase
    end
  end

  assign txEndEvt = bitTick && stateQ != TFC_IDLE && stateD == TFC_IDLE;
  assign loadWait = origin ? rxFrameEnd : txEndEvt;
  assign unitLen = unitEtu ? 12'(HALF_BIT_CYC) : 12'(CARR_CYC);

  always_comb begin
    waitCntD = waitCntQ;
    unitDivD = unitDivQ;
    // counter loads at the end event: rx frame end when origin is set, else tx end
    if (loadWait) begin
      waitCntD = waitCount;
      unitDivD = unitLen - 12'h001;
    end else if (waitCntQ != 11'h000) begin
      if (unitDivQ == 12'h000) begin
        waitCntD = waitCntQ - 11'h001;
        unitDivD = unitLen - 12'h001;
      end else begin
        unitDivD = unitDivQ - 12'h001;
      end
    end
    busyD = (waitCntD != 11'h000);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      halfDivQ <= 12'h000;
      halfPhaseQ <= 1'b0;
      stateQ <= TFC_IDLE;
      bitIdxQ <= 9'h000;
      curByteQ <= 8'h00;
      txOutQ <= 1'b0;
      symQ <= 2'h0;
      activeQ <= 1'b0;
      pendQ <= 1'b0;
      waitCntQ <= 11'h000;
      unitDivQ <= 12'h000;
      busyQ <= 1'b0;
    end else begin
      halfDivQ <= halfDivD;
      halfPhaseQ <= halfPhaseD;
      stateQ <= stateD;
      bitIdxQ <= bitIdxD;
      curByteQ <= curByteD;
      txOutQ <= txOutD;
      symQ <= symD;
      activeQ <= activeD;
      pendQ <= pendD;
      waitCntQ <= waitCntD;
      unitDivQ <= unitDivD;
      busyQ <= busyD;
    end
  end
  assign txOut = txOutQ;
  assign txSymbol = symQ;
  assign txActive = activeQ;
  assign waitBusy = busyQ;

  // Receive byte assembly; parity bit stays out of the byte
  logic [3:0] rxCntQ, rxCntD;
  tfc_byte_t rxShQ, rxShD, rxByteQ, rxByteD;
  logic rxValQ, rxValD, rxErrQ, rxErrD;
  always_comb begin
    rxCntD = rxCntQ;
    rxShD = rxShQ;
    rxByteD = rxByteQ;
    rxValD = 1'b0;
    rxErrD = 1'b0;
    if (rxFrameEnd) begin
      rxCntD = 4'h0;
    end else if (rxBitValid) begin
      if (rxCntQ == 4'h8) begin
        rxValD = 1'b1;
        rxByteD = rxShQ;
        rxErrD = (^rxShQ) ^ `TFC_ODD_PARITY ^ rxBit;
        rxCntD = 4'h0;
      end else begin
        rxShD = {rxBit, rxShQ[7:1]};
        rxCntD = rxCntQ + 4'h1;
        if (rxCntQ == 4'h7 && !rxPar) begin
          rxValD = 1'b1;
          rxByteD = {rxBit, rxShQ[7:1]};
          rxCntD = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxCntQ <= 4'h0;
      rxShQ <= 8'h00;
      rxByteQ <= 8'h00;
      rxValQ <= 1'b0;
      rxErrQ <= 1'b0;
    end else begin
      rxCntQ <= rxCntD;
      rxShQ <= rxShD;
      rxByteQ <= rxByteD;
      rxValQ <= rxValD;
      rxErrQ <= rxErrD;
    end
  end
  assign rxByte = rxByteQ;
  assign rxByteValid = rxValQ;
  assign rxParityErr = rxErrQ;

  property p_start_after_wait;
    @(posedge sys_clk) disable iff (rst)
    (stateQ == TFC_IDLE && stateD != TFC_IDLE) |-> (waitCntQ == 11'h000);
  endproperty
  a_start_after_wait: assert property (p_start_after_wait) else $error("start during wait");
  property p_tx_origin;
    @(posedge sys_clk) disable iff (rst)
    (!origin && txEndEvt) |=> (waitCntQ == $past(waitCount));
  endproperty
  a_tx_origin: assert property (p_tx_origin) else $error("wait not loaded at tx end");
  property p_rx_origin;
    @(posedge sys_clk) disable iff (rst)
    (origin && rxFrameEnd && !regWe) |=> (waitCntQ == $past(waitCount));
  endproperty
  a_rx_origin: assert property (p_rx_origin) else $error("wait not loaded at rx end");
  property p_par_follows;
    @(posedge sys_clk) disable iff (rst)
    (stateQ == TFC_DATA && bitTick && bitIdxQ == 9'h007 && txPar) |=> (stateQ == TFC_PAR);
  endproperty
  a_par_follows: assert property (p_par_follows) else $error("parity bit missing");
  property p_par_value;
    @(posedge sys_clk) disable iff (rst)
    (stateQ == TFC_PAR) |-> (txOutQ == ((^curByteQ) ^ `TFC_ODD_PARITY));
  endproperty
  a_par_value: assert property (p_par_value) else $error("wrong parity value");
  property p_stop_typeb;
    @(posedge sys_clk) disable iff (rst)
    (stateQ == TFC_STOP) |-> (txOutQ && stopLen != 3'h0);
  endproperty
  a_stop_typeb: assert property (p_stop_typeb) else $error("stop bit out of mode");
  property p_rx_par_byte;
    @(posedge sys_clk) disable iff (rst)
    (rxBitValid && !rxFrameEnd && rxCntQ == 4'h8) |=> rxValQ ##1 !rxValQ;
  endproperty
  a_rx_par_byte: assert property (p_rx_par_byte) else $error("rx byte not after parity");
  property p_wait_unit;
    @(posedge sys_clk) disable iff (rst)
    (waitCntQ > 11'h001 && !loadWait && unitDivQ == 12'h000 && !unitEtu)
      |=> (unitDivQ == 12'(CARR_CYC - 1));
  endproperty
  a_wait_unit: assert property (p_wait_unit) else $error("carrier unit wrong");
endmodule : tfc_framer

/* test/tfc_tag_model.sv */
// Purpose: Contactless tag on the far side of the RF field
// Assumes: One bit period is BIT_CYC sys_clk cycles; txActive rises on a bit boundary
// Notes: Logs each frame bit as {symbol, level}; answers only when the bench asks
module tfc_tag_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic txOut,
  input wire logic [1:0] txSymbol,
  input wire logic txActive,
  output logic rxBit,
  output logic rxBitValid,
  output logic rxFrameEnd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] seen[$];
  int phase = 0;

  initial begin
    rxBit = 1'b0;
    rxBitValid = 1'b0;
    rxFrameEnd = 1'b0;
  end

  // Mid-bit sampling keeps clear of the bit edges
  always @(posedge sys_clk) begin
    if (txActive !== 1'b1) begin
      phase <= 0;
    end else begin
      if (phase == BIT_CYC / 2) seen.push_back({txSymbol, txOut});
      phase <= (phase == BIT_CYC - 1) ? 0 : phase + 1;
    end
  end

  // a parity bit follows each answered byte; odd unless badPar is set
  task automatic answer(input logic [7:0] b, input logic badPar);
    logic [8:0] w;
    w = {~^b ^ badPar, b};
    for (int i = 0; i < 9; i++) begin
      rxBit = w[i];
      rxBitValid = 1'b1;
      @(posedge sys_clk);
      #1;
      rxBitValid = 1'b0;
      rxBit = ~w[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
      #1;
    end
  endtask : answer

  task automatic frame_end();
    rxFrameEnd = 1'b1;
    @(posedge sys_clk);
    #1;
    rxFrameEnd = 1'b0;
  endtask : frame_end
endmodule : tfc_tag_model

/* test/tx_frame_timing_config_test.sv */
// Purpose: Self-checking bench of the transmit framer with a tag model
// Assumes: HALF_BIT_CYC of 4, so one bit lasts 8 cycles
// Notes: Inputs change 1 ns after the rising edge
module tx_frame_timing_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tfc_pkg::*;
  localparam int HB = 4;
  localparam int LIM = 20000;
  localparam int BL[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
  logic sys_clk, rst, regWe, regRe, txByteValid, txStart, typeBMode, txByteReady;
  logic txOut, txActive, waitBusy, rxBit, rxBitValid, rxFrameEnd, rxByteValid, rxParityErr;
  logic [7:0] regAddr;
  logic [1:0] txSymbol, op, cl;
  logic [2:0] bc, st;
  logic par, tb, errGot;
  tfc_byte_t regWdata, regRdata, txByte, rxByte, rxGot, d;
  tfc_byte_t bq[$];
  logic [2:0] expQ[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h301dbb67;
  int rxCnt = 0;
  int busyCnt, waitCyc, n, w;

  tfc_framer #(.HALF_BIT_CYC(HB), .FIFO_DEPTH(16)) DUT (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWe(regWe), .regRe(regRe), .regWdata(regWdata), .regRdata(regRdata),
    .txByte(txByte), .txByteValid(txByteValid), .txByteReady(txByteReady), .txStart(txStart),
    .typeBMode(typeBMode), .txOut(txOut), .txSymbol(txSymbol), .txActive(txActive),
    .waitBusy(waitBusy), .rxBit(rxBit), .rxBitValid(rxBitValid), .rxFrameEnd(rxFrameEnd),
    .rxByte(rxByte), .rxByteValid(rxByteValid), .rxParityErr(rxParityErr));
  tfc_tag_model #(.BIT_CYC(2 * HB)) M (.sys_clk(sys_clk), .txOut(txOut), .txSymbol(txSymbol),
    .txActive(txActive), .rxBit(rxBit), .rxBitValid(rxBitValid), .rxFrameEnd(rxFrameEnd));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (rxByteValid === 1'b1) begin
      rxGot <= rxByte;
      errGot <= rxParityErr;
      rxCnt <= rxCnt + 1;
    end
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic limit(input int t);
    if (t >= LIM) begin
      num_errors++;
      $display("[ERR] wait bound used up");
      close_out();
    end
  endtask : limit

  task automatic wr(input logic [7:0] a, input tfc_byte_t v);
    regAddr = a;
    regWdata = v;
    regWe = 1'b1;
    tick();
    regWe = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input tfc_byte_t exp);
    regAddr = a;
    regRe = 1'b1;
    tick();
    regRe = 1'b0;
    check("register read", exp, regRdata);
  endtask : rd_chk

  // Valid stays up between bytes; the caller lowers it
  task automatic push(input tfc_byte_t b);
    int t;
    t = 0;
    txByte = b;
    txByteValid = 1'b1;
    while (txByteReady !== 1'b1 && t < LIM) begin
      tick();
      t++;
    end
    limit(t);
    tick();
  endtask : push

  function automatic void build(input logic [1:0] o, c, input logic [2:0] b, s,
      input logic p, y);
    expQ.delete();
    repeat ((o == 2'h2) ? BL[b] : int'(o != 2'h0)) expQ.push_back({o, o == 2'h2});
    foreach (bq[k]) begin
      for (int i = 0; i < 8; i++) expQ.push_back({2'h0, bq[k][i]});
      if (p) expQ.push_back({2'h0, ~^bq[k]});
    end
    if (y) repeat (s) expQ.push_back(3'b001);
    if (c != 2'h0) expQ.push_back({c, c == 2'h2});
  endfunction : build

  task automatic run_frame();
    int t;
    t = 0;
    busyCnt = 0;
    M.seen.delete();
    txStart = 1'b1;
    tick();
    txStart = 1'b0;
    while (txActive !== 1'b1 && t < LIM) begin
      if (waitBusy === 1'b1) busyCnt++;
      tick();
      t++;
    end
    waitCyc = t;
    while (txActive === 1'b1 && t < LIM) begin
      tick();
      t++;
    end
    limit(t);
    check("frame length", expQ.size(), M.seen.size());
    foreach (expQ[i]) if (i < M.seen.size()) check("frame bit", expQ[i], M.seen[i]);
  endtask : run_frame

  initial begin
    {rst, regWe, regRe, txByteValid, txStart, typeBMode} = 6'h20;
    {regAddr, regWdata, txByte} = 24'h000000;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    tick();
    rd_chk(8'h31, 8'hC0);
    foreach (BL[a]) if (a < 5) rd_chk(8'h30 + 8'(a), (a == 1) ? 8'hC0 : 8'h00);
    for (int a = 0; a < 5; a++) begin
      d = 8'($random(seed));
      wr(8'h30 + 8'(a), d);
      rd_chk(8'h30 + 8'(a), d & ((a == 0) ? 8'h70 : (a == 3) ? 8'hCF : (a == 4) ? 8'h00 : 8'hFF));
    end
    for (int i = 0; i < 12; i++) begin
      op = (i < 8) ? 2'h2 : 2'(i - 8);
      bc = 3'(i);
      cl = 2'(i);
      st = 3'(i);
      par = i[0];
      tb = !(i == 3 || i == 9);
      typeBMode = tb;
      wr(8'h30, {1'b0, bc, 4'h0});
      wr(8'h31, {5'h00, st});
      wr(8'h33, {par, 3'b000, cl, op});
      wr(8'h32, 8'h00);
      bq.delete();
      n = (i == 11) ? 0 : 1 + $unsigned($random(seed)) % 3;
      repeat (n) bq.push_back(8'($random(seed)));
      foreach (bq[k]) push(bq[k]);
      txByteValid = 1'b0;
      build(op, cl, bc, st, par, tb);
      run_frame();
    end
    // sixteen bytes fill the buffer, a seventeenth is refused
    bq.delete();
    repeat (16) bq.push_back(8'($random(seed)));
    foreach (bq[k]) push(bq[k]);
    txByteValid = 1'b0;
    tick();
    tick();
    check("buffer full", 0, txByteReady);
    push_refused();
    build(2'h3, 2'h3, 3'h3, 3'h0, 1'b1, 1'b0);
    typeBMode = 1'b0;
    run_frame();
    // wait in carrier units, then in half bits with upper count bits
    wr(8'h33, 8'h05);
    bq.delete();
    build(2'h1, 2'h1, 3'h0, 3'h0, 1'b0, 1'b0);
    for (int u = 0; u < 2; u++) begin
      wr(8'h31, u ? 8'h48 : 8'h00);
      wr(8'h32, u ? 8'h05 : 8'h03);
      w = u ? 261 * HB : 3 * 118;
      run_frame();
      run_frame();
      check("busy span", 1, busyCnt + 3 >= w && busyCnt <= w + 1);
      check("tx gap", 1, waitCyc + 2 >= w);
    end
    // origin on rx end: tx end loads nothing
    wr(8'h31, 8'hC0);
    wr(8'h32, 8'h0A);
    wr(8'h33, 8'h45);
    run_frame();
    run_frame();
    check("busy after tx", 0, busyCnt);
    for (int b = 0; b < 2; b++) begin
      d = 8'($random(seed));
      M.answer(d, b[0]);
      check("rx byte", d, rxGot);
      check("rx parity flag", b, errGot);
      check("rx count", b + 1, rxCnt);
    end
    M.frame_end();
    run_frame();
    check("rx wait span", 1, busyCnt + 3 >= 10 * HB && busyCnt <= 10 * HB + 1);
    close_out();
  end

  task automatic push_refused();
    txByte = 8'hA5;
    txByteValid = 1'b1;
    repeat (3) tick();
    txByteValid = 1'b0;
  endtask : push_refused
endmodule : tx_frame_timing_config_test
